// ### hw/jtbs_pkg.sv
// Constants, opcodes, state codes and field layouts for the boundary scan TAP.
// Assumes every user includes nothing and refers to items as jtbs_pkg::name.
package jtbs_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_IO = 4;               // I/O cells on the device
   localparam int CELLS_PER_IO = 3;         // Input, output and enable cell
   localparam int BSR_LEN = NUM_IO * CELLS_PER_IO;
   localparam int IR_W = 8;
   localparam int ID_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int SYNC_STAGES = 2;

   // Cell position within one I/O group of the boundary register
   localparam int CELL_IN = 0;
   localparam int CELL_OUT = 1;
   localparam int CELL_OE = 2;

   // ----------------------------------------------------------------
   // Instruction opcodes
   // ----------------------------------------------------------------
   localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
   localparam logic [IR_W-1:0] OP_SAMPLE = 8'h01;
   localparam logic [IR_W-1:0] OP_CLAMP = 8'h05;
   localparam logic [IR_W-1:0] OP_HIGHZ = 8'h07;
   localparam logic [IR_W-1:0] OP_USERCODE = 8'h0E;
   localparam logic [IR_W-1:0] OP_IDCODE = 8'h0F;
   localparam logic [IR_W-1:0] OP_BYPASS = 8'hFF;
   localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;   // Fixed pattern loaded in Capture-IR

   // ----------------------------------------------------------------
   // Identification fields; all values arbitrary
   // ----------------------------------------------------------------
   localparam logic [3:0] ID_VERSION = 4'h1;
   localparam logic [15:0] ID_PART = 16'h0A5C;
   localparam logic [10:0] ID_MAKER = 11'h2B5;
   localparam logic ID_MARKER = 1'b1;
   localparam logic [ID_W-1:0] USER_RESET = 32'h00000000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      TAP_RESET = 4'hF, TAP_IDLE = 4'hC,
      TAP_SEL_DR = 4'h7, TAP_CAP_DR = 4'h6, TAP_SH_DR = 4'h2, TAP_EX1_DR = 4'h1,
      TAP_PAU_DR = 4'h3, TAP_EX2_DR = 4'h0, TAP_UPD_DR = 4'h5,
      TAP_SEL_IR = 4'h4, TAP_CAP_IR = 4'hE, TAP_SH_IR = 4'hA, TAP_EX1_IR = 4'h9,
      TAP_PAU_IR = 4'hB, TAP_EX2_IR = 4'h8, TAP_UPD_IR = 4'hD
   } jtbs_tap_e;

   typedef enum logic [1:0] {
      SEL_BYPASS = 2'h0,
      SEL_ID = 2'h1,
      SEL_BSR = 2'h2
   } jtbs_sel_e;

endpackage

// ### hw/jtbs_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs.
// Assumes the inputs are levels that stay stable for several clk periods.
`timescale 1ns/10ps
module jtbs_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   input wire logic [W-1:0] rst_val,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } jtbs_sync_s;

   jtbs_sync_s st;
   jtbs_sync_s next_st;

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   // First stage feeds only the second stage
   always_comb
   begin
      next_st = st;
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   // Reset to zero; rst_val is applied on the output side so no port feeds a reset
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   assign q = st.s2 ^ rst_val;

endmodule // jtbs_sync

// ### hw/jtbs_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; pointers carry one extra wrap bit.
`timescale 1ns/10ps
module jtbs_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } jtbs_fifo_s;

   jtbs_fifo_s st;
   jtbs_fifo_s next_st;
   logic full;
   logic empty;

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   // Equal pointers mean empty; equal except wrap bit means full
   assign empty = (st.wp == st.rp);
   assign full = (st.wp[AW-1:0] == st.rp[AW-1:0]) && (st.wp[AW] != st.rp[AW]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = st.mem[st.rp[AW-1:0]];

   // ----------------------------------------------------------------
   // Pointer and storage update
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      if (in_valid && !full)
      begin
         next_st.mem[st.wp[AW-1:0]] = in_data;
         next_st.wp = st.wp + 1'b1;
      end
      if (out_ready && !empty)
         next_st.rp = st.rp + 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

endmodule // jtbs_fifo

// ### hw/jtbs_tap.sv
// Boundary scan test access port: TAP controller, instruction register,
// bypass, identification and boundary scan data registers.
// Assumes tck, tms, tdi and pad inputs are asynchronous to clk and that tck
// runs well below a quarter of the clk rate, so every tck edge is seen.
// What this block does
// - Three data registers selectable: bypass, identification, boundary scan.
// - Bypass register sits in the path whenever no other register is addressed.
// - Identification register is 32 bits: marker, maker, part and version fields.
// - Three boundary cells per I/O, each with serial and parallel ports.
// - Boundary register observes and controls every I/O pin.
// - Sixteen-state controller with a 4-bit code, standard transition graph.
// - Transitions follow TMS sampled at rising TCK; host sets TMS beforehand.
// - Controller derives register controls from TMS and TCK.
// - Power-up lands in Test-Logic-Reset without any TCK edge.
// - Five TCK edges with TMS high reach Test-Logic-Reset from anywhere.
// - TRST forces Test-Logic-Reset asynchronously.
// - No entry into test mode while the freeze pin is asserted.
// - Opcodes EXTEST 00, SAMPLE/PRELOAD 01, BYPASS FF are decoded.
// - Opcode 0F is IDCODE, selecting the identification register.
// - Opcodes HIGHZ 07, USERCODE 0E and CLAMP 05 are decoded.
// - All boundary cells form one chain from TDI to TDO.
// - Test port is TCK, TDI, TDO, TMS and TRST.
`timescale 1ns/10ps
module jtbs_tap (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo,
   output logic tdo_oe,
   input wire logic freeze,
   input wire logic [jtbs_pkg::NUM_IO-1:0] core_out,
   input wire logic [jtbs_pkg::NUM_IO-1:0] core_oe,
   output logic [jtbs_pkg::NUM_IO-1:0] core_in,
   input wire logic [jtbs_pkg::NUM_IO-1:0] pad_in,
   output logic [jtbs_pkg::NUM_IO-1:0] pad_out,
   output logic [jtbs_pkg::NUM_IO-1:0] pad_oe,
   input wire logic user_valid,
   output logic user_ready,
   input wire logic [jtbs_pkg::ID_W-1:0] user_data,
   output logic [3:0] tap_state,
   output logic test_active
);

   localparam int N = jtbs_pkg::NUM_IO;
   localparam int L = jtbs_pkg::BSR_LEN;
   localparam int IW = jtbs_pkg::IR_W;
   localparam int DW = jtbs_pkg::ID_W;

   typedef struct packed {
      jtbs_pkg::jtbs_tap_e state;
      logic tck_d;
      logic [IW-1:0] ir;
      logic [IW-1:0] ir_sh;
      logic byp;
      logic [DW-1:0] id_sh;
      logic [DW-1:0] user_code;
      logic [L-1:0] bsr_sh;
      logic [L-1:0] bsr_upd;
      logic tdo;
      logic tdo_oe;
   } jtbs_tap_s;

   jtbs_tap_s st;
   jtbs_tap_s next_st;

   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic freeze_s;
   logic [N-1:0] pad_s;
   logic tck_rise;
   logic tck_fall;
   logic tap_rst_n;
   logic [L-1:0] bsr_cap;
   logic [DW-1:0] id_word;
   logic fifo_valid;
   logic fifo_pop;
   logic [DW-1:0] fifo_data;
   jtbs_pkg::jtbs_sel_e sel;
   logic drive_pads;
   logic pads_off;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // The tck, tms, tdi, freeze and pad inputs come from outside the clk domain
   jtbs_sync #(.W(4 + N)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({tck, tms, tdi, freeze, pad_in}),
      .rst_val({4'h0, {N{1'b0}}}),
      .q({tck_s, tms_s, tdi_s, freeze_s, pad_s})
   );

   // Edge detection of the sampled test clock
   assign tck_rise = tck_s && !st.tck_d;
   assign tck_fall = !tck_s && st.tck_d;

   // TRST acts without any clock, as does power-up reset
   assign tap_rst_n = rst_n & trst_n;

   // ----------------------------------------------------------------
   // User code queue
   // ----------------------------------------------------------------
   // Each Capture-DR under USERCODE takes the next queued word; the
   // source stalls on user_ready once eight words wait
   jtbs_fifo #(.W(DW), .DEPTH(jtbs_pkg::FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(user_valid),
      .in_ready(user_ready),
      .in_data(user_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   // ----------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------
   // Unlisted opcodes fall to bypass, as do BYPASS, HIGHZ and CLAMP
   always_comb
   begin
      case (st.ir)
         jtbs_pkg::OP_EXTEST,
         jtbs_pkg::OP_SAMPLE: sel = jtbs_pkg::SEL_BSR;
         jtbs_pkg::OP_IDCODE,
         jtbs_pkg::OP_USERCODE: sel = jtbs_pkg::SEL_ID;
         default: sel = jtbs_pkg::SEL_BYPASS;
      endcase
   end

   assign drive_pads = (st.ir == jtbs_pkg::OP_EXTEST) || (st.ir == jtbs_pkg::OP_CLAMP);
   assign pads_off = (st.ir == jtbs_pkg::OP_HIGHZ);

   // Identification word: version, part, maker, marker
   assign id_word = {jtbs_pkg::ID_VERSION, jtbs_pkg::ID_PART, jtbs_pkg::ID_MAKER,
                     jtbs_pkg::ID_MARKER};

   // ----------------------------------------------------------------
   // Boundary cells
   // ----------------------------------------------------------------
   // Capture sees the pin for inputs and the core for output and enable
   always_comb
   begin
      bsr_cap = '0;
      for (int i = 0; i < N; i++)
      begin
         bsr_cap[i * 3 + jtbs_pkg::CELL_IN] = pad_s[i];
         bsr_cap[i * 3 + jtbs_pkg::CELL_OUT] = core_out[i];
         bsr_cap[i * 3 + jtbs_pkg::CELL_OE] = core_oe[i];
      end
   end

   // Parallel outputs of the update stage steer pads and core
   always_comb
   begin
      pad_out = core_out;
      pad_oe = core_oe;
      core_in = pad_s;
      for (int i = 0; i < N; i++)
      begin
         if (drive_pads)
         begin
            pad_out[i] = st.bsr_upd[i * 3 + jtbs_pkg::CELL_OUT];
            pad_oe[i] = st.bsr_upd[i * 3 + jtbs_pkg::CELL_OE];
         end
         if (pads_off)
            pad_oe[i] = 1'b0;
         if (st.ir == jtbs_pkg::OP_EXTEST)
            core_in[i] = st.bsr_upd[i * 3 + jtbs_pkg::CELL_IN];
      end
   end

   // ----------------------------------------------------------------
   // Controller transition graph
   // ----------------------------------------------------------------
   function automatic jtbs_pkg::jtbs_tap_e tap_next(input jtbs_pkg::jtbs_tap_e s, input logic m);
      jtbs_pkg::jtbs_tap_e n;
      n = jtbs_pkg::TAP_RESET;
      case (s)
         jtbs_pkg::TAP_RESET: n = m ? jtbs_pkg::TAP_RESET : jtbs_pkg::TAP_IDLE;
         jtbs_pkg::TAP_IDLE: n = m ? jtbs_pkg::TAP_SEL_DR : jtbs_pkg::TAP_IDLE;
         jtbs_pkg::TAP_SEL_DR: n = m ? jtbs_pkg::TAP_SEL_IR : jtbs_pkg::TAP_CAP_DR;
         jtbs_pkg::TAP_CAP_DR: n = m ? jtbs_pkg::TAP_EX1_DR : jtbs_pkg::TAP_SH_DR;
         jtbs_pkg::TAP_SH_DR: n = m ? jtbs_pkg::TAP_EX1_DR : jtbs_pkg::TAP_SH_DR;
         jtbs_pkg::TAP_EX1_DR: n = m ? jtbs_pkg::TAP_UPD_DR : jtbs_pkg::TAP_PAU_DR;
         jtbs_pkg::TAP_PAU_DR: n = m ? jtbs_pkg::TAP_EX2_DR : jtbs_pkg::TAP_PAU_DR;
         jtbs_pkg::TAP_EX2_DR: n = m ? jtbs_pkg::TAP_UPD_DR : jtbs_pkg::TAP_SH_DR;
         jtbs_pkg::TAP_UPD_DR: n = m ? jtbs_pkg::TAP_SEL_DR : jtbs_pkg::TAP_IDLE;
         jtbs_pkg::TAP_SEL_IR: n = m ? jtbs_pkg::TAP_RESET : jtbs_pkg::TAP_CAP_IR;
         jtbs_pkg::TAP_CAP_IR: n = m ? jtbs_pkg::TAP_EX1_IR : jtbs_pkg::TAP_SH_IR;
         jtbs_pkg::TAP_SH_IR: n = m ? jtbs_pkg::TAP_EX1_IR : jtbs_pkg::TAP_SH_IR;
         jtbs_pkg::TAP_EX1_IR: n = m ? jtbs_pkg::TAP_UPD_IR : jtbs_pkg::TAP_PAU_IR;
         jtbs_pkg::TAP_PAU_IR: n = m ? jtbs_pkg::TAP_EX2_IR : jtbs_pkg::TAP_PAU_IR;
         jtbs_pkg::TAP_EX2_IR: n = m ? jtbs_pkg::TAP_UPD_IR : jtbs_pkg::TAP_SH_IR;
         jtbs_pkg::TAP_UPD_IR: n = m ? jtbs_pkg::TAP_SEL_DR : jtbs_pkg::TAP_IDLE;
         default: n = jtbs_pkg::TAP_RESET;
      endcase
      return n;
   endfunction

   // The USERCODE capture drains one queued word when there is one
   assign fifo_pop = tck_rise && (st.state == jtbs_pkg::TAP_CAP_DR) &&
                     (st.ir == jtbs_pkg::OP_USERCODE);

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Register actions happen at the rising test clock edge in the state
   // being left, which matches the standard's capture/shift/update timing
   always_comb
   begin
      next_st = st;
      next_st.tck_d = tck_s;
      if (tck_rise)
      begin
         next_st.state = tap_next(st.state, tms_s);
         case (st.state)
            jtbs_pkg::TAP_RESET: next_st.ir = jtbs_pkg::OP_IDCODE;
            jtbs_pkg::TAP_CAP_IR: next_st.ir_sh = jtbs_pkg::IR_CAPTURE;
            jtbs_pkg::TAP_SH_IR: next_st.ir_sh = {tdi_s, st.ir_sh[IW-1:1]};
            jtbs_pkg::TAP_UPD_IR: next_st.ir = st.ir_sh;
            jtbs_pkg::TAP_CAP_DR:
            begin
               case (sel)
                  jtbs_pkg::SEL_BSR: next_st.bsr_sh = bsr_cap;
                  jtbs_pkg::SEL_ID:
                  begin
                     if (st.ir == jtbs_pkg::OP_USERCODE)
                     begin
                        // Empty queue repeats the last word rather than stalling the test
                        next_st.id_sh = fifo_valid ? fifo_data : st.user_code;
                        if (fifo_valid)
                           next_st.user_code = fifo_data;
                     end
                     else
                        next_st.id_sh = id_word;
                  end
                  default: next_st.byp = 1'b0;
               endcase
            end
            jtbs_pkg::TAP_SH_DR:
            begin
               case (sel)
                  jtbs_pkg::SEL_BSR: next_st.bsr_sh = {tdi_s, st.bsr_sh[L-1:1]};
                  jtbs_pkg::SEL_ID: next_st.id_sh = {tdi_s, st.id_sh[DW-1:1]};
                  default: next_st.byp = tdi_s;
               endcase
            end
            jtbs_pkg::TAP_UPD_DR:
            begin
               // SAMPLE/PRELOAD also updates, so EXTEST starts from preloaded values
               if (sel == jtbs_pkg::SEL_BSR)
                  next_st.bsr_upd = st.bsr_sh;
            end
            default: next_st.byp = st.byp;
         endcase
      end
      // Serial output moves on the falling test clock edge only
      if (tck_fall)
      begin
         next_st.tdo_oe = (st.state == jtbs_pkg::TAP_SH_DR) || (st.state == jtbs_pkg::TAP_SH_IR);
         if (st.state == jtbs_pkg::TAP_SH_IR)
            next_st.tdo = st.ir_sh[0];
         else
         begin
            case (sel)
               jtbs_pkg::SEL_BSR: next_st.tdo = st.bsr_sh[0];
               jtbs_pkg::SEL_ID: next_st.tdo = st.id_sh[0];
               default: next_st.tdo = st.byp;
            endcase
         end
      end
      // While frozen the controller is held in reset so test mode cannot start
      if (freeze_s)
      begin
         next_st.state = jtbs_pkg::TAP_RESET;
         next_st.ir = jtbs_pkg::OP_IDCODE;
         next_st.tdo_oe = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Power-up or TRST resets without waiting for any tck edge
   always_ff @(posedge clk or negedge tap_rst_n)
   begin
      if (!tap_rst_n)
      begin
         st <= '0;
         st.state <= jtbs_pkg::TAP_RESET;
         st.ir <= jtbs_pkg::OP_IDCODE;
         st.user_code <= jtbs_pkg::USER_RESET;
         st.tck_d <= 1'b1; // A fall, never a rise, may follow reset
      end
      else
         st <= next_st;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign tdo = st.tdo;
   assign tdo_oe = st.tdo_oe;
   assign tap_state = st.state;
   assign test_active = drive_pads || pads_off;

endmodule // jtbs_tap

// ### verification/jtbs_tap_sva.sv
// Concurrent checks on the ports of the boundary scan TAP.
// Assumes tck phases last 4 clk or more and all pins move on clk edges.
`timescale 1ns/10ps
module jtbs_tap_sva (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic trst_n,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic freeze,
   input wire logic [jtbs_pkg::NUM_IO-1:0] core_out,
   input wire logic [jtbs_pkg::NUM_IO-1:0] core_oe,
   input wire logic [jtbs_pkg::NUM_IO-1:0] core_in,
   input wire logic [jtbs_pkg::NUM_IO-1:0] pad_in,
   input wire logic [jtbs_pkg::NUM_IO-1:0] pad_out,
   input wire logic [jtbs_pkg::NUM_IO-1:0] pad_oe,
   input wire logic [3:0] tap_state,
   input wire logic test_active
);
   // ------
   // Next state by state code, for tms low and tms high
   // ------
   localparam logic [3:0] NX0 [16] = '{4'h2, 4'h3, 4'h2, 4'h3, 4'hE, 4'hC, 4'h2, 4'h6,
      4'hA, 4'hB, 4'hA, 4'hB, 4'hC, 4'hC, 4'hA, 4'hC};
   localparam logic [3:0] NX1 [16] = '{4'h5, 4'h5, 4'h1, 4'h0, 4'hF, 4'h7, 4'h1, 4'h4,
      4'hD, 4'hD, 4'h9, 4'h8, 4'h7, 4'h7, 4'h9, 4'hF};
   logic tck_q;
   logic [2:0] ones;

   // Rises seen in a row with tms high; saturates so it cannot wrap
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tck_q <= 1'b0;
         ones <= 3'h0;
      end
      else
      begin
         tck_q <= tck;
         if (tck && !tck_q)
            ones <= tms ? ones + {2'h0, ones != 3'h5} : 3'h0;
      end
   end

   // ------
   // Checks; test reset counts as a reset of the controller
   // ------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n || !trst_n);

   trst_force_a: assert property (disable iff (!rst_n) !trst_n |-> tap_state == 4'hF && !tdo_oe)
      else $error("state not reset under trst_n");
   graph_step_a: assert property (!$stable(tap_state) && !freeze |->
      tap_state == ($past(tms, 2) ? NX1[$past(tap_state)] : NX0[$past(tap_state)]))
      else $error("state step off the graph");
   rise_only_a: assert property (!$stable(tap_state) && !freeze |-> $past(tck, 2))
      else $error("state moved without a tck rise");
   tdo_fall_a: assert property (!$stable(tdo) && !freeze |-> !$past(tck, 2))
      else $error("tdo moved outside a tck low phase");
   oe_shift_a: assert property ($rose(tdo_oe) |-> tap_state == 4'h2 || tap_state == 4'hA)
      else $error("tdo driven outside a shift state");
   oe_release_a: assert property ($fell(tdo_oe) |-> tap_state != 4'h2 && tap_state != 4'hA)
      else $error("tdo released inside a shift state");
   freeze_hold_a: assert property (freeze [*5] |-> tap_state == 4'hF && !tdo_oe)
      else $error("controller left reset under freeze");
   five_ones_a: assert property (ones == 3'h5 |-> ##[0:4] tap_state == 4'hF)
      else $error("five tms ones did not reset");
   pad_follow_a: assert property (!test_active |-> pad_out == core_out && pad_oe == core_oe)
      else $error("pads not following core");
   core_input_a: assert property (!test_active && $past(rst_n, 3) |-> core_in == $past(pad_in, 2))
      else $error("core input not following pad");
endmodule // jtbs_tap_sva

bind jtbs_tap jtbs_tap_sva u_sva (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .trst_n(trst_n),
   .tdo(tdo), .tdo_oe(tdo_oe), .freeze(freeze), .core_out(core_out), .core_oe(core_oe),
   .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
   .tap_state(tap_state), .test_active(test_active));

// ### verification/jtbs_host.sv
// Test host model: drives tck, tms and tdi and reads tdo.
// Assumes the TAP needs 4 clk per tck phase; tck stands still between calls.
`timescale 1ns/10ps
module jtbs_host (
   input wire logic clk,
   input wire logic tdo,
   output logic tck,
   output logic tms,
   output logic tdi
);
   // Idle levels follow the pull-ups on tms and tdi
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // One 80 ns period: fall with new tms and tdi, rise 4 clk later
   task automatic step(input logic m, input logic d, output logic q);
      @(posedge clk);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      q = tdo;
   endtask

   // Walk n states, tms bits taken lowest first; eight ones reset from anywhere
   task automatic walk(input logic [7:0] seq, input int n);
      logic q;
      for (int i = 0; i < n; i++)
         step(seq[i], 1'b1, q);
   endtask

   // Shift n bits lowest first, leaving the shift state on the last one
   task automatic shift(input int n, input logic [63:0] din, output logic [63:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++)
         step(i == n - 1, din[i], dout[i]);
   endtask

   // Both scans start and end in Run-Test/Idle
   task automatic ir_scan(input logic [7:0] op, output logic [7:0] cap);
      logic [63:0] o;
      walk(8'h03, 4);
      shift(8, {56'h0, op}, o);
      cap = o[7:0];
      walk(8'h01, 2);
   endtask

   task automatic dr_scan(input int n, input logic [63:0] din, output logic [63:0] dout);
      walk(8'h01, 3);
      shift(n, din, dout);
      walk(8'h01, 2);
   endtask
endmodule // jtbs_host

// ### verification/jtbs_tap_tb.sv
// Self-checking bench for the boundary scan TAP.
// Assumes the host model supplies tck, tms and tdi; bench drives the rest.
`timescale 1ns/10ps
module jtbs_tap_tb;
   logic clk, rst_n, trst_n, freeze, tck, tms, tdi, tdo, tdo_oe, user_valid, user_ready, test_active;
   logic [jtbs_pkg::NUM_IO-1:0] core_out, core_oe, core_in, pad_in, pad_out, pad_oe;
   logic [3:0] tap_state;
   logic [31:0] user_data;
   logic [63:0] o;
   logic [7:0] c;
   int err_count, samples_checked;

   // 100 MHz clock
   initial clk = 1'b0;
   always #5 clk = ~clk;

   jtbs_tap dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
      .tdo_oe(tdo_oe), .freeze(freeze), .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .user_valid(user_valid),
      .user_ready(user_ready), .user_data(user_data), .tap_state(tap_state), .test_active(test_active));
   // Released tdo reads inverted, exposing a late or missing enable
   jtbs_host host (.clk(clk), .tdo(tdo_oe ? tdo : !tdo), .tck(tck), .tms(tms), .tdi(tdi));

   // ------
   // Compare, verdict and cell layout
   // ------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("mismatches=%0d compares=%0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Input cell lowest, then output and enable, per I/O
   function automatic logic [11:0] cells(input logic [3:0] pin, input logic [3:0] out, input logic [3:0] oe);
      for (int i = 0; i < 4; i++)
         cells[i*3 +: 3] = {oe[i], out[i], pin[i]};
   endfunction

   // ------
   // Scenarios
   // ------
   task automatic t_idcode();
      host.walk(8'h00, 1);
      host.dr_scan(40, 64'hA5, o);
      chk(o[31:0], {jtbs_pkg::ID_VERSION, jtbs_pkg::ID_PART, jtbs_pkg::ID_MAKER, jtbs_pkg::ID_MARKER});
      chk(o[39:32], 8'hA5);
   endtask

   // Every opcode plus one unlisted: IR capture, mode flag and path length
   task automatic t_opcodes();
      logic [7:0] ops [8] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h0E, 8'h0F, 8'hFF, 8'h3C};
      int lens [8] = '{12, 12, 1, 1, 32, 32, 1, 1};
      logic act [8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      for (int k = 0; k < 8; k++)
      begin
         host.ir_scan(ops[k], c);
         chk(c, jtbs_pkg::IR_CAPTURE);
         chk(test_active, act[k]);
         host.dr_scan(lens[k] + 8, 64'h5A, o);
         chk(o >> lens[k], 64'h5A);
         if (lens[k] == 1)
            chk(o[0], 1'b0);
      end
   endtask

   // Sample and preload, then drive pads from the update stage
   task automatic t_pads();
      host.ir_scan(jtbs_pkg::OP_SAMPLE, c);
      host.dr_scan(12, {52'h0, cells(4'h9, 4'h6, 4'hF)}, o);
      chk(o[11:0], cells(4'h3, 4'hA, 4'h5));
      host.ir_scan(jtbs_pkg::OP_EXTEST, c);
      chk({pad_out, pad_oe, core_in}, {4'h6, 4'hF, 4'h9});
      host.ir_scan(jtbs_pkg::OP_CLAMP, c);
      chk({pad_out, pad_oe}, {4'h6, 4'hF});
      host.ir_scan(jtbs_pkg::OP_HIGHZ, c);
      chk(pad_oe, 4'h0);
      host.ir_scan(jtbs_pkg::OP_BYPASS, c);
      chk({pad_out, pad_oe}, {4'hA, 4'h5});
   endtask

   // Five ones from Shift-IR and from Pause-DR
   task automatic t_five();
      host.walk(8'h03, 4);
      host.walk(8'h1F, 5);
      chk(tap_state, 4'hF);
      host.walk(8'h0A, 5);
      chk(tap_state, 4'h3);
      host.walk(8'h1F, 5);
      chk(tap_state, 4'hF);
   endtask

   // Test reset in Shift-DR takes effect before any clock edge
   task automatic t_trst();
      host.walk(8'h02, 4);
      chk(tap_state, 4'h2);
      @(posedge clk);
      trst_n <= 1'b0;
      @(negedge clk);
      chk(tap_state, 4'hF);
      @(posedge clk);
      trst_n <= 1'b1;
   endtask

   // Freeze keeps the controller out of test; leaving it restores control
   task automatic t_freeze();
      @(posedge clk);
      freeze <= 1'b1;
      host.walk(8'h02, 4);
      chk({tap_state, tdo_oe}, {4'hF, 1'b0});
      @(posedge clk);
      freeze <= 1'b0;
      repeat (4) @(posedge clk);
      host.walk(8'h02, 4);
      chk(tap_state, 4'h2);
   endtask

   // Fill the FIFO until it refuses, then drain it by slow USERCODE scans
   task automatic t_fifo();
      int acc;
      acc = 0;
      host.walk(8'h03, 3);
      @(posedge clk);
      user_valid <= 1'b1;
      user_data <= 32'hC0DE0000;
      for (int i = 0; i < 12; i++)
      begin
         @(negedge clk);
         if (user_ready === 1'b1)
            acc++;
         @(posedge clk);
         user_data <= 32'hC0DE0000 + acc;
      end
      user_valid <= 1'b0;
      chk(acc, jtbs_pkg::FIFO_DEPTH);
      host.ir_scan(jtbs_pkg::OP_USERCODE, c);
      for (int k = 0; k < 9; k++)
      begin
         host.dr_scan(32, 64'h0, o);
         chk(o[31:0], 32'hC0DE0000 + (k < 8 ? k : 7));
      end
   endtask

   // Main sequence; all inputs set at time zero
   initial
   begin
      rst_n = 1'b0;
      trst_n = 1'b1;
      freeze = 1'b0;
      core_out = 4'hA;
      core_oe = 4'h5;
      pad_in = 4'h3;
      user_valid = 1'b0;
      user_data = 32'h0;
      err_count = 0;
      samples_checked = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk({tap_state, tdo_oe}, {4'hF, 1'b0});
      t_idcode();
      t_opcodes();
      t_pads();
      t_five();
      t_trst();
      t_freeze();
      t_fifo();
      summarize();
   end

   // Watchdog, several times the expected run length
   initial
   begin
      #500000;
      err_count++;
      summarize();
   end
endmodule // jtbs_tap_tb
